//--- logic/rfc_cfg.svh
// register map, field positions, reset values and widths of the converter control block
`ifndef RFC_CFG_SVH
`define RFC_CFG_SVH
`define CNT_W 24
`define CNT_MAX 24'hFFFFFF
`define CNT_ZERO 24'h000000
`define CNT_ONE 24'h000001
`define OFS_CLK 8'h00
`define OFS_CTL 8'h04
`define OFS_TRG 8'h08
`define OFS_FLG 8'h0C
`define OFS_MC 8'h10
`define OFS_TC 8'h14
`define CLK_SRC_BIT 0
`define CLK_DIV_LSB 4
`define CLK_GATE_BIT 8
`define CTL_EN_BIT 0
`define CTL_EVT_BIT 1
`define CTL_CON_BIT 2
`define TRG_REF_BIT 0
`define TRG_SA_BIT 1
`define TRG_SB_BIT 2
`define FLG_REF_BIT 0
`define FLG_TCOV_BIT 1
`define FLG_MCOV_BIT 2
`define FLG_SA_BIT 3
`define FLG_SB_BIT 4
`define FLG_W 5
`define SRC_RST 1'b1
`define DIV_RST 2'h0
`define DIV_W 2
`define PRE_W 3
`define PRE_M1 3'h0
`define PRE_M2 3'h1
`define PRE_M4 3'h3
`define PRE_M8 3'h7
`endif

//--- logic/rfc_pkg.sv
// types shared by the converter control block
package rfc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REF = 2'b01,
    ST_SENA = 2'b10,
    ST_SENB = 2'b11
  } osc_state_t;
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drv_t;
endpackage

//--- logic/res_freq_converter.sv
// resistance-to-frequency converter: time base clock, counters, oscillation control, pins
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "rfc_cfg.svh"
module res_freq_converter
  import rfc_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // oscillator sources
  input wire logic low_speed_osc,
  input wire logic high_speed_osc,
  input wire logic cr_osc_clock,
  // port function select
  input wire logic conv_pin_sel,
  // converter pins
  input wire logic osc_input_pin_in,
  output pin_drv_t osc_input_pin,
  output pin_drv_t sensor_a_pin,
  output pin_drv_t sensor_b_pin,
  output pin_drv_t reference_pin,
  output logic osc_monitor_out
);
  logic tb_source_select_r, tb_clock_gate_on_r, conv_en_r;
  logic external_count_mode_r, continuous_osc_on_r;
  logic [`DIV_W-1:0] tb_divider_ratio_r;
  osc_state_t state_r, state_nxt;
  logic [`FLG_W-1:0] flags_r, flag_set;
  logic [`CNT_W-1:0] measure_counter_r, time_base_counter_r;
  logic [`PRE_W-1:0] pre_r, pre_mask;
  logic ls_prev_r, hs_prev_r, osc_prev_r, osc_src, osc_edge, ls_edge, hs_edge;
  logic time_base_clock, running, sensing, mc_wrap, tc_wrap, tc_zero, auto_stop;
  logic wr_clk, wr_ctl, wr_trg, wr_flg, wr_mc, wr_tc;

  assign wr_clk = wr && (addr == ADDR_W'(`OFS_CLK));
  assign wr_ctl = wr && (addr == ADDR_W'(`OFS_CTL));
  assign wr_trg = wr && (addr == ADDR_W'(`OFS_TRG));
  assign wr_flg = wr && (addr == ADDR_W'(`OFS_FLG));
  assign wr_mc = wr && (addr == ADDR_W'(`OFS_MC));
  assign wr_tc = wr && (addr == ADDR_W'(`OFS_TC));

  // edge detection of the synchronous clock sources
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ls_prev_r <= 1'b0;
      hs_prev_r <= 1'b0;
      osc_prev_r <= 1'b0;
    end
    else
    begin
      ls_prev_r <= low_speed_osc;
      hs_prev_r <= high_speed_osc;
      osc_prev_r <= osc_src;
    end
  end

  assign ls_edge = low_speed_osc && !ls_prev_r;
  assign hs_edge = high_speed_osc && !hs_prev_r;
  assign osc_src = external_count_mode_r ? osc_input_pin_in : cr_osc_clock;
  assign osc_edge = osc_src && !osc_prev_r;

  always_comb
  begin
    unique case (tb_divider_ratio_r)
      2'h0: pre_mask = `PRE_M1;
      2'h1: pre_mask = `PRE_M2;
      2'h2: pre_mask = `PRE_M4;
      2'h3: pre_mask = `PRE_M8;
    endcase
  end

  // high-speed prescaler, frozen while the gate is off
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pre_r <= `PRE_M1;
    else if (tb_clock_gate_on_r && !tb_source_select_r && hs_edge)
      pre_r <= pre_r + 3'h1;
  end

  assign time_base_clock = tb_clock_gate_on_r && (tb_source_select_r ? ls_edge
    : (hs_edge && ((pre_r & pre_mask) == pre_mask)));

  // configuration registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tb_source_select_r <= `SRC_RST;
      tb_divider_ratio_r <= `DIV_RST;
      tb_clock_gate_on_r <= 1'b0;
      conv_en_r <= 1'b0;
      external_count_mode_r <= 1'b0;
      continuous_osc_on_r <= 1'b0;
    end
    else if (wr_clk)
    begin
      tb_source_select_r <= wdata[`CLK_SRC_BIT];
      tb_divider_ratio_r <= wdata[`CLK_DIV_LSB +: `DIV_W];
      tb_clock_gate_on_r <= wdata[`CLK_GATE_BIT];
    end
    else if (wr_ctl)
    begin
      conv_en_r <= wdata[`CTL_EN_BIT];
      external_count_mode_r <= wdata[`CTL_EVT_BIT];
      continuous_osc_on_r <= wdata[`CTL_CON_BIT];
    end
  end

  // stop conditions, shared by internal and external modes
  assign running = state_r != ST_IDLE;
  assign sensing = (state_r == ST_SENA) || (state_r == ST_SENB);
  assign mc_wrap = running && osc_edge && (measure_counter_r == `CNT_MAX);
  assign tc_wrap = (state_r == ST_REF) && time_base_clock && (time_base_counter_r == `CNT_MAX);
  assign tc_zero = sensing && time_base_clock && (time_base_counter_r == `CNT_ONE);
  assign auto_stop = !continuous_osc_on_r && (mc_wrap || tc_wrap || tc_zero);

  always_comb
  begin
    state_nxt = state_r;
    if (wr_trg)
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (conv_en_r && wdata[`TRG_REF_BIT])
            state_nxt = ST_REF;
          else if (conv_en_r && wdata[`TRG_SA_BIT])
            state_nxt = ST_SENA;
          else if (conv_en_r && wdata[`TRG_SB_BIT])
            state_nxt = ST_SENB;
        end
        ST_REF: if (!wdata[`TRG_REF_BIT]) state_nxt = ST_IDLE;
        ST_SENA: if (!wdata[`TRG_SA_BIT]) state_nxt = ST_IDLE;
        ST_SENB: if (!wdata[`TRG_SB_BIT]) state_nxt = ST_IDLE;
      endcase
    end
    if (auto_stop)
      state_nxt = ST_IDLE;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // five sticky causes, cleared by writing 1, set wins
  always_comb
  begin
    flag_set = '0;
    flag_set[`FLG_REF_BIT] = (state_r == ST_REF) && mc_wrap;
    flag_set[`FLG_TCOV_BIT] = tc_wrap;
    flag_set[`FLG_MCOV_BIT] = sensing && mc_wrap;
    flag_set[`FLG_SA_BIT] = (state_r == ST_SENA) && tc_zero;
    flag_set[`FLG_SB_BIT] = (state_r == ST_SENB) && tc_zero;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flags_r <= '0;
    else
      flags_r <= (flags_r & ~(wr_flg ? wdata[`FLG_W-1:0] : '0)) | flag_set;
  end

  // 24-bit counters; software load wins over counting
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      measure_counter_r <= `CNT_ZERO;
    else if (wr_mc)
      measure_counter_r <= wdata[`CNT_W-1:0];
    else if (running && osc_edge)
      measure_counter_r <= measure_counter_r + `CNT_ONE;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      time_base_counter_r <= `CNT_ZERO;
    else if (wr_tc)
      time_base_counter_r <= wdata[`CNT_W-1:0];
    else if ((state_r == ST_REF) && time_base_clock)
      time_base_counter_r <= time_base_counter_r + `CNT_ONE;
    else if (sensing && time_base_clock)
      time_base_counter_r <= time_base_counter_r - `CNT_ONE;
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= '0;
    else if (rd)
    begin
      rdata <= '0;
      unique case (addr)
        ADDR_W'(`OFS_CLK):
        begin
          rdata[`CLK_SRC_BIT] <= tb_source_select_r;
          rdata[`CLK_DIV_LSB +: `DIV_W] <= tb_divider_ratio_r;
          rdata[`CLK_GATE_BIT] <= tb_clock_gate_on_r;
        end
        ADDR_W'(`OFS_CTL):
        begin
          rdata[`CTL_EN_BIT] <= conv_en_r;
          rdata[`CTL_EVT_BIT] <= external_count_mode_r;
          rdata[`CTL_CON_BIT] <= continuous_osc_on_r;
        end
        ADDR_W'(`OFS_TRG):
        begin
          rdata[`TRG_REF_BIT] <= state_r == ST_REF;
          rdata[`TRG_SA_BIT] <= state_r == ST_SENA;
          rdata[`TRG_SB_BIT] <= state_r == ST_SENB;
        end
        ADDR_W'(`OFS_FLG): rdata[`FLG_W-1:0] <= flags_r;
        ADDR_W'(`OFS_MC): rdata[`CNT_W-1:0] <= measure_counter_r;
        ADDR_W'(`OFS_TC): rdata[`CNT_W-1:0] <= time_base_counter_r;
        default: rdata <= '0;
      endcase
    end
  end

  // pin drivers and monitor output
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      osc_input_pin <= '0;
      sensor_a_pin <= '0;
      sensor_b_pin <= '0;
      reference_pin <= '0;
      osc_monitor_out <= 1'b0;
    end
    else
    begin
      osc_monitor_out <= running && osc_src;
      osc_input_pin.o <= 1'b0;
      osc_input_pin.oe <= conv_pin_sel && !running;
      reference_pin.o <= cr_osc_clock;
      reference_pin.oe <= conv_pin_sel && !external_count_mode_r && (state_r == ST_REF);
      sensor_a_pin.o <= cr_osc_clock;
      sensor_a_pin.oe <= conv_pin_sel && !external_count_mode_r && (state_r == ST_SENA);
      sensor_b_pin.o <= cr_osc_clock;
      sensor_b_pin.oe <= conv_pin_sel && !external_count_mode_r && (state_r == ST_SENB);
    end
  end

  sequence s_ref_wrap;
    (state_r == ST_REF) && mc_wrap && !continuous_osc_on_r;
  endsequence
  sequence s_ref_done;
    (state_r == ST_IDLE) && flags_r[`FLG_REF_BIT];
  endsequence
  property p_ref_stop;
    @(posedge clk) disable iff (rst) s_ref_wrap |=> s_ref_done;
  endproperty
  a_ref_stop: assert property (p_ref_stop) else $error("reference did not stop on wrap");
  property p_sen_stop;
    @(posedge clk) disable iff (rst)
      (state_r == ST_SENA) && tc_zero && !continuous_osc_on_r && !wr_tc
      |=> (state_r == ST_IDLE) && flags_r[`FLG_SA_BIT] && (time_base_counter_r == `CNT_ZERO);
  endproperty
  a_sen_stop: assert property (p_sen_stop) else $error("sensor A did not end at zero");
  property p_gate_off;
    @(posedge clk) disable iff (rst)
      !tb_clock_gate_on_r && !wr_tc |=> $stable(time_base_counter_r);
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("time base moved with gate off");
  property p_ls_direct;
    @(posedge clk) disable iff (rst)
      tb_clock_gate_on_r && tb_source_select_r && ls_edge && (state_r == ST_REF) && !wr_tc
      |=> time_base_counter_r == $past(time_base_counter_r) + `CNT_ONE;
  endproperty
  a_ls_direct: assert property (p_ls_direct) else $error("low-speed tick lost");
  property p_div8;
    @(posedge clk) disable iff (rst)
      tb_clock_gate_on_r && !tb_source_select_r && (tb_divider_ratio_r == 2'h3)
      && time_base_clock |-> (pre_r == `PRE_M8);
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 ticks wrongly");
  property p_cont;
    @(posedge clk) disable iff (rst)
      continuous_osc_on_r && running && !wr_trg |=> state_r == $past(state_r);
  endproperty
  a_cont: assert property (p_cont) else $error("continuous oscillation stopped");
  property p_monitor;
    @(posedge clk) disable iff (rst) !running |=> !osc_monitor_out;
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor active while idle");
  property p_idle_low;
    @(posedge clk) disable iff (rst)
      conv_pin_sel && !running |=> osc_input_pin.oe && !osc_input_pin.o
      && !reference_pin.oe && !sensor_a_pin.oe;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("idle pin levels wrong");
  property p_abort;
    @(posedge clk) disable iff (rst)
      (state_r == ST_REF) && wr_trg && !wdata[`TRG_REF_BIT]
      |=> (state_r == ST_IDLE) ##1 ($stable(measure_counter_r) || $past(wr_mc));
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not hold counters");
endmodule

//--- test/osc_model.sv
// free-running oscillator sources at the far side of the converter
`timescale 1ns/1ps
module osc_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // oscillator levels
  output logic low_speed_osc,
  output logic high_speed_osc,
  output logic cr_osc_clock,
  output logic ext_pulse
);
  logic [2:0] div_r;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      div_r <= 3'h0;
    else
      div_r <= div_r + 3'h1;
  // rising edges every 8, 2, 4 and 2 cycles
  assign low_speed_osc = div_r[2];
  assign high_speed_osc = div_r[0];
  assign cr_osc_clock = div_r[1];
  assign ext_pulse = ~div_r[0];
endmodule

//--- test/tb.sv
// self-checking testbench for the converter control block
`timescale 1ns/1ps
`include "rfc_cfg.svh"
module tb;
  import rfc_pkg::*;
  logic clk, rst, wr, rd, sel, lso, hso, cro, ext, mon;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v, w;
  logic [3:0] pins_mid;
  pin_drv_t p_osc, p_a, p_b, p_ref;
  int bad_count, comparisons, mon_cnt, mon_mid;
  res_freq_converter i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .low_speed_osc(lso), .high_speed_osc(hso), .cr_osc_clock(cro),
    .conv_pin_sel(sel), .osc_input_pin_in(ext), .osc_input_pin(p_osc), .sensor_a_pin(p_a),
    .sensor_b_pin(p_b), .reference_pin(p_ref), .osc_monitor_out(mon));
  osc_model i_osc (.clk(clk), .rst(rst), .low_speed_osc(lso), .high_speed_osc(hso),
    .cr_osc_clock(cro), .ext_pulse(ext));
  always @(posedge mon)
    mon_cnt++;
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", n, exp, got);
      bad_count++;
    end
  endtask
  // tolerance covers edge-detector and strobe alignment
  task automatic near(input string n, input logic [31:0] got, input logic [31:0] exp);
    chk(n, {31'h0, (got + 2 >= exp) && (got <= exp + 2)}, 32'h1);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic run_for(input logic [31:0] trg);
    int m0;
    wr_reg(`OFS_TRG, trg);
    m0 = mon_cnt;
    repeat (32) @(posedge clk);
    pins_mid = {p_osc.oe, p_a.oe, p_b.oe, p_ref.oe};
    mon_mid = mon_cnt - m0;
    repeat (32) @(posedge clk);
    wr_reg(`OFS_TRG, 32'h0);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 200; k++)
    begin
      rd_reg(`OFS_TRG, v);
      if (v[2:0] === 3'h0)
        return;
    end
    chk("wait_idle", 32'h1, 32'h0);
    summarize();
  endtask
  task automatic t_reset();
    rd_reg(`OFS_CLK, v);
    chk("clk_reg", v, 32'h00000001);
    rd_reg(`OFS_MC, v);
    chk("mc_rst", v, 32'h0);
    rd_reg(8'h20, v);
    chk("unmapped", v, 32'h0);
    wr_reg(`OFS_TC, 32'hFFFFFFFF);
    rd_reg(`OFS_TC, v);
    chk("tc_width", v, 32'h00FFFFFF);
  endtask
  task automatic t_gate();
    wr_reg(`OFS_CLK, 32'h0);
    wr_reg(`OFS_TC, 32'h0);
    wr_reg(`OFS_MC, 32'h0);
    run_for(32'h1);
    rd_reg(`OFS_TC, v);
    chk("tc_gated", v, 32'h0);
    rd_reg(`OFS_TRG, v);
    chk("trg_abort", v, 32'h0);
    rd_reg(`OFS_MC, v);
    repeat (20) @(posedge clk);
    rd_reg(`OFS_MC, w);
    chk("mc_hold", w, v);
  endtask
  task automatic t_div();
    for (int d = 0; d < 5; d++)
    begin
      w = (d == 4) ? 32'h00000131 : (32'h00000100 | (d << `CLK_DIV_LSB));
      wr_reg(`OFS_CLK, w);
      wr_reg(`OFS_TC, 32'h0);
      run_for(32'h1);
      rd_reg(`OFS_TC, v);
      near("tc_rate", v, (d == 4) ? 32'h8 : (32'h21 >> d));
    end
    wr_reg(`OFS_CLK, 32'h00000100);
  endtask
  task automatic t_ext();
    for (int e = 0; e < 2; e++)
    begin
      wr_reg(`OFS_CTL, 32'h1 | (e << `CTL_EVT_BIT));
      wr_reg(`OFS_MC, 32'h0);
      run_for(32'h1);
      rd_reg(`OFS_MC, v);
      near("mc_count", v, e ? 32'h21 : 32'h10);
      chk("pins_run", {28'h0, pins_mid}, e ? 32'h0 : 32'h1);
      chk("mon_run", {31'h0, mon_mid > 4}, 32'h1);
    end
    wr_reg(`OFS_CTL, 32'h1);
  endtask
  task automatic t_stops();
    logic [31:0] trg [5] = '{32'h1, 32'h1, 32'h2, 32'h4, 32'h4};
    logic [31:0] mci [5] = '{32'hFFFFF0, 32'h0, 32'h0, 32'hFFFFFE, 32'h0};
    logic [31:0] tci [5] = '{32'h0, 32'hFFFFF8, 32'h4, 32'h400, 32'h4};
    logic [31:0] flg [5] = '{32'h01, 32'h02, 32'h08, 32'h04, 32'h10};
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(`OFS_FLG, 32'h1F);
      wr_reg(`OFS_MC, mci[i]);
      wr_reg(`OFS_TC, tci[i]);
      wr_reg(`OFS_TRG, trg[i]);
      wait_idle();
      rd_reg(`OFS_FLG, v);
      chk("flags", v, flg[i]);
      rd_reg((i == 0 || i == 3) ? `OFS_MC : `OFS_TC, v);
      chk("wrapped", v, 32'h0);
    end
    chk("osc_pin_idle", {30'h0, p_osc}, 32'h1);
    chk("pins_idle", {29'h0, p_a.oe, p_b.oe, p_ref.oe}, 32'h0);
    chk("mon_idle", {31'h0, mon}, 32'h0);
  endtask
  task automatic t_cont();
    wr_reg(`OFS_CTL, 32'h5);
    wr_reg(`OFS_FLG, 32'h1F);
    wr_reg(`OFS_MC, 32'hFFFFF0);
    wr_reg(`OFS_TRG, 32'h1);
    repeat (100) @(posedge clk);
    rd_reg(`OFS_TRG, v);
    chk("cont_run", v, 32'h1);
    rd_reg(`OFS_FLG, v);
    chk("cont_flag", v & 32'h1, 32'h1);
    wr_reg(`OFS_TRG, 32'h0);
    wr_reg(`OFS_CTL, 32'h1);
  endtask
  task automatic t_pins();
    for (int s = 1; s < 3; s++)
    begin
      wr_reg(`OFS_TC, 32'h100);
      wr_reg(`OFS_TRG, 32'h1 << s);
      repeat (4) @(posedge clk);
      #1 chk("pins_sen", {28'h0, p_osc.oe, p_a.oe, p_b.oe, p_ref.oe}, 32'h8 >> s);
      wr_reg(`OFS_TRG, 32'h0);
    end
    @(posedge clk);
    #1 v[0] = cro;
    @(posedge clk);
    #1 chk("pin_level", {29'h0, p_a.o, p_b.o, p_ref.o}, {29'h0, {3{v[0]}}});
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    sel = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    wr_reg(`OFS_CLK, 32'h00000100);
    sel <= 1'b1;
    wr_reg(`OFS_CTL, 32'h1);
    t_gate();
    t_div();
    t_ext();
    t_pins();
    t_stops();
    t_cont();
    summarize();
  end
endmodule
